// File: verilog/rtcts_regs.svh
// Purpose: register map, field positions, reset values and rates
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef RTCTS_REGS_SVH
`define RTCTS_REGS_SVH

// ****************************************************************
// register indices
// ****************************************************************
`define RTS_IDX_STATUS   6'h03
`define RTS_IDX_CONTROL  6'h07
`define RTS_IDX_TRIM     6'h08
`define RTS_IDX_DN_MIN   6'h18
`define RTS_IDX_DN_HOUR  6'h19
`define RTS_IDX_DN_DATE  6'h1a
`define RTS_IDX_DN_MTH   6'h1b
`define RTS_IDX_UP_MIN   6'h1c
`define RTS_IDX_UP_HOUR  6'h1d
`define RTS_IDX_UP_DATE  6'h1e
`define RTS_IDX_UP_MTH   6'h1f

// ****************************************************************
// field positions
// ****************************************************************
`define RTS_CTL_OUT      7
`define RTS_CTL_CLKEN    6
`define RTS_CTL_EXT_CLOCK_IN_EN   3
`define RTS_CTL_COARSE   2
`define RTS_STS_OSCST    7
`define RTS_STS_BACKUP   5
`define RTS_STS_PLF      4
`define RTS_STS_BKEN     3
`define RTS_TRIM_SIGN    7
`define RTS_FS_1HZ       2'h0
`define RTS_FS_4K        2'h1
`define RTS_FS_8K        2'h2

// ****************************************************************
// reset values and writable masks
// ****************************************************************
`define RTS_RST_BYTE     8'h00
`define RTS_MASK_MIN     8'h7f
`define RTS_MASK_HOUR    8'h7f
`define RTS_MASK_DATE    8'h3f
`define RTS_MASK_MTH     8'hff
`define RTS_MASK_STS     8'h98

// ****************************************************************
// rates
// ****************************************************************
`define RTS_OSC_HZ       32768
`define RTS_COARSE_HZ    128
`define RTS_SECS_PER_MIN 60

`endif

// File: verilog/rtcts_pkg.sv
// Purpose: shared types of the trim and time-stamp block
// Assumes: nothing
// Notes:   constants live in rtcts_regs.svh
package rtcts_pkg;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic [7:0] month;
      logic [7:0] date;
      logic [7:0] hours;
      logic [7:0] minutes;
   } rtcts_stamp_t;

   typedef enum logic [0:0] {
      PWR_PRIMARY = 1'b0,
      PWR_BACKUP  = 1'b1
   } rtcts_pwr_t;

endpackage

// File: verilog/rtcts_top.sv
// Purpose: oscillator trim, supply switchover and power-fail stamps
// Assumes: osc_tick is a one-cycle pulse per oscillator cycle;
//          pclk is far faster than the oscillator
// Notes:   APB slave, zero wait states, pslverr on backup
//
// Register access over APB was decided locally.
`include "rtcts_regs.svh"

module rtcts_top #(
   parameter int SEC_TICKS = `RTS_OSC_HZ
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output logic                       pready,
   output logic [31:0]                prdata,
   output logic                       pslverr,
   input  wire logic                  osc_tick,
   input  wire logic                  below_switchover_threshold,
   input  wire rtcts_pkg::rtcts_stamp_t cur_time,
   output logic                       trim_tick,
   output logic                       on_backup,
   output logic                       serial_bus_en,
   output logic                       multi_function_pin_o,
   output logic                       multi_function_pin_oe
);
   import rtcts_pkg::*;

   localparam int COARSE_T = `RTS_OSC_HZ / `RTS_COARSE_HZ;

   // ****************************************************************
   // state
   // ****************************************************************
   logic [7:0]   control_q;
   logic [7:0]   trim_q;
   logic         osc_start_q;
   logic         backup_input_en_q;
   logic         power_loss_flag_q;
   logic         armed_q;
   rtcts_pwr_t   pwr_q;
   rtcts_pwr_t   pwr_d;
   rtcts_stamp_t stamp_q [2];
   logic [7:0]   pend_q;
   logic         pend_add_q;
   logic [14:0]  sub_q;
   logic [5:0]   sec_q;
   logic         osc_lvl_q;
   logic         trim_tick_q;
   logic         mfp_lvl_q;
   logic         mfp_act_q;
   logic [31:0]  prdata_q;

   logic [6:0]   trim_count;
   logic         osc_en;
   logic         tick;
   logic         fine_wrap;
   logic         coarse_wrap;
   logic         trim_evt;
   logic         pend_busy;
   logic         wr_en;
   logic [5:0]   idx;
   logic         idx_ok;
   logic         go_down;
   logic         go_up;
   logic         plf_clr;

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic map_hit(input logic [5:0] i);
      map_hit = (i == `RTS_IDX_STATUS) || (i == `RTS_IDX_CONTROL) ||
                (i == `RTS_IDX_TRIM) ||
                (i >= `RTS_IDX_DN_MIN && i <= `RTS_IDX_UP_MTH);
   endfunction

   // keep reserved stamp bits at zero
   function automatic rtcts_stamp_t clean(input rtcts_stamp_t s);
      clean.minutes = s.minutes & `RTS_MASK_MIN;
      clean.hours   = s.hours & `RTS_MASK_HOUR;
      clean.date    = s.date & `RTS_MASK_DATE;
      clean.month   = s.month & `RTS_MASK_MTH;
   endfunction

   function automatic logic [7:0] stamp_byte(input rtcts_stamp_t s,
                                             input logic [1:0]   f);
      unique case (f)
         2'h0: stamp_byte = s.minutes;
         2'h1: stamp_byte = s.hours;
         2'h2: stamp_byte = s.date;
         2'h3: stamp_byte = s.month;
      endcase
   endfunction

   // ****************************************************************
   // apb decode
   // ****************************************************************
   assign idx    = paddr[7:2];
   assign idx_ok = map_hit(idx) && (paddr[1:0] == 2'h0);
   // bus is dead while running from backup
   assign pready  = psel & penable;
   assign pslverr = psel & penable & (~idx_ok | (pwr_q == PWR_BACKUP));
   assign wr_en   = psel & penable & pwrite & pstrb[0] & ~pslverr;
   assign prdata  = prdata_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
      end else if (psel & ~penable & ~pwrite) begin
         prdata_q <= '0;
         if (idx_ok && (pwr_q == PWR_PRIMARY)) begin
            unique case (idx)
               `RTS_IDX_STATUS: begin
                  prdata_q[`RTS_STS_OSCST]  <= osc_start_q;
                  prdata_q[`RTS_STS_BACKUP] <= (pwr_q == PWR_BACKUP);
                  prdata_q[`RTS_STS_PLF]    <= power_loss_flag_q;
                  prdata_q[`RTS_STS_BKEN]   <= backup_input_en_q;
               end
               `RTS_IDX_CONTROL: prdata_q[7:0] <= control_q;
               `RTS_IDX_TRIM:    prdata_q[7:0] <= trim_q;
               default: begin
                  prdata_q[7:0] <= stamp_byte(stamp_q[idx[2]], idx[1:0]);
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // control and trim registers
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_q <= `RTS_RST_BYTE;
      end else if (wr_en && idx == `RTS_IDX_CONTROL) begin
         control_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trim_q <= `RTS_RST_BYTE;
      end else if (wr_en && idx == `RTS_IDX_TRIM) begin
         trim_q <= pwdata[7:0];
      end
   end

   assign trim_count = trim_q[6:0];

   // ****************************************************************
   // status register
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_start_q       <= 1'b0;
         backup_input_en_q <= 1'b0;
      end else if (wr_en && idx == `RTS_IDX_STATUS) begin
         osc_start_q       <= pwdata[`RTS_STS_OSCST];
         backup_input_en_q <= pwdata[`RTS_STS_BKEN];
      end
   end

   assign plf_clr = wr_en && idx == `RTS_IDX_STATUS && !pwdata[`RTS_STS_PLF];

   // ****************************************************************
   // supply switchover
   // ****************************************************************
   always_comb begin
      pwr_d = pwr_q;
      unique case (pwr_q)
         PWR_PRIMARY: begin
            if (backup_input_en_q && below_switchover_threshold) begin
               pwr_d = PWR_BACKUP;
            end
         end
         PWR_BACKUP: begin
            if (!below_switchover_threshold || !backup_input_en_q) begin
               pwr_d = PWR_PRIMARY;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_q <= PWR_PRIMARY;
      end else begin
         pwr_q <= pwr_d;
      end
   end

   assign go_down = (pwr_q == PWR_PRIMARY) && (pwr_d == PWR_BACKUP);
   assign go_up   = (pwr_q == PWR_BACKUP) && (pwr_d == PWR_PRIMARY);

   // ****************************************************************
   // power-fail stamps
   // ****************************************************************
   // armed: a down stamp was taken with the flag clear, so the
   // matching up stamp may still be logged
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_q <= 1'b0;
      end else if (go_down) begin
         armed_q <= ~power_loss_flag_q;
      end else if (go_up) begin
         armed_q <= 1'b0;
      end
   end

   // capture beats a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_loss_flag_q <= 1'b0;
      end else if (go_down || go_up) begin
         power_loss_flag_q <= 1'b1;
      end else if (plf_clr) begin
         power_loss_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stamp_q[0] <= '0;
         stamp_q[1] <= '0;
      end else if (go_down && !power_loss_flag_q) begin
         stamp_q[0] <= clean(cur_time);
      end else if (go_up && armed_q) begin
         stamp_q[1] <= clean(cur_time);
      end else if (plf_clr && power_loss_flag_q) begin
         stamp_q[0] <= '0;
         stamp_q[1] <= '0;
      end else if (wr_en && idx >= `RTS_IDX_DN_MIN) begin
         unique case (idx[1:0])
            2'h0: stamp_q[idx[2]].minutes <= pwdata[7:0] & `RTS_MASK_MIN;
            2'h1: stamp_q[idx[2]].hours   <= pwdata[7:0] & `RTS_MASK_HOUR;
            2'h2: stamp_q[idx[2]].date    <= pwdata[7:0] & `RTS_MASK_DATE;
            2'h3: stamp_q[idx[2]].month   <= pwdata[7:0];
         endcase
      end
   end

   // ****************************************************************
   // digital trim
   // ****************************************************************
   // trimming keeps running on backup
   assign osc_en    = osc_tick & (osc_start_q | control_q[`RTS_CTL_EXT_CLOCK_IN_EN]);
   assign pend_busy = (pend_q != 8'h00);

   // add: insert ticks in idle cycles; remove: swallow real ticks
   always_comb begin
      tick = osc_en;
      if (pend_busy && pend_add_q) begin
         tick = ~osc_en | osc_en;
      end else if (pend_busy) begin
         tick = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sub_q <= '0;
         sec_q <= '0;
      end else if (tick) begin
         if (sub_q == 15'(SEC_TICKS - 1)) begin
            sub_q <= '0;
            sec_q <= (sec_q == 6'(`RTS_SECS_PER_MIN - 1)) ? 6'h00 : sec_q + 6'h01;
         end else begin
            sub_q <= sub_q + 15'h0001;
         end
      end
   end

   assign fine_wrap   = tick && sub_q == 15'(SEC_TICKS - 1) &&
                        sec_q == 6'(`RTS_SECS_PER_MIN - 1);
   assign coarse_wrap = tick && sub_q[7:0] == 8'(COARSE_T - 1);
   assign trim_evt    = control_q[`RTS_CTL_COARSE] ? coarse_wrap
                                                   : fine_wrap;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q     <= 8'h00;
         pend_add_q <= 1'b0;
      end else if (trim_evt && trim_count != 7'h00) begin
         pend_q     <= {trim_count, 1'b0};
         pend_add_q <= trim_q[`RTS_TRIM_SIGN];
      end else if (pend_busy && (pend_add_q ? ~osc_en : osc_en)) begin
         pend_q <= pend_q - 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trim_tick_q <= 1'b0;
      end else begin
         trim_tick_q <= tick;
      end
   end

   assign trim_tick = trim_tick_q;

   // ****************************************************************
   // multi-function pin
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_lvl_q <= 1'b0;
      end else if (osc_en) begin
         osc_lvl_q <= ~osc_lvl_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mfp_lvl_q <= 1'b1;
         mfp_act_q <= 1'b0;
      end else if (pwr_q == PWR_BACKUP) begin
         mfp_lvl_q <= 1'b1;
         mfp_act_q <= 1'b0;
      end else if (control_q[`RTS_CTL_CLKEN] && control_q[`RTS_CTL_COARSE]) begin
         mfp_lvl_q <= sub_q[8];
         mfp_act_q <= 1'b1;
      end else if (control_q[`RTS_CTL_CLKEN]) begin
         unique case (control_q[1:0])
            `RTS_FS_1HZ: mfp_lvl_q <= sub_q[14];
            `RTS_FS_4K:  mfp_lvl_q <= sub_q[2];
            `RTS_FS_8K:  mfp_lvl_q <= sub_q[1];
            default:     mfp_lvl_q <= osc_lvl_q;
         endcase
         mfp_act_q <= 1'b1;
      end else begin
         mfp_lvl_q <= control_q[`RTS_CTL_OUT];
         mfp_act_q <= 1'b1;
      end
   end

   // open drain: pull low only
   assign multi_function_pin_o  = 1'b0;
   assign multi_function_pin_oe = mfp_act_q & ~mfp_lvl_q;

   assign on_backup     = (pwr_q == PWR_BACKUP);
   assign serial_bus_en = (pwr_q == PWR_PRIMARY);

endmodule

// File: bench/rtcts_properties.sv
// Purpose: port checks of switchover, refusal on backup and stamp fields
// Assumes: zero-wait register bus, prdata loaded in the setup cycle
// Notes:   bound into every rtcts_top
`include "rtcts_regs.svh"

module rtcts_properties
   import rtcts_pkg::*;
(
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [7:0]              paddr,
   input wire logic [31:0]             pwdata,
   input wire logic [3:0]              pstrb,
   input wire logic                    pready,
   input wire logic [31:0]             prdata,
   input wire logic                    pslverr,
   input wire logic                    osc_tick,
   input wire logic                    below_switchover_threshold,
   input wire rtcts_pkg::rtcts_stamp_t cur_time,
   input wire logic                    trim_tick,
   input wire logic                    on_backup,
   input wire logic                    serial_bus_en,
   input wire logic                    multi_function_pin_o,
   input wire logic                    multi_function_pin_oe
);
   // ****************************************************************
   // checks
   // ****************************************************************
   logic       rd_acc;
   logic [5:0] idx;
   assign rd_acc = psel && penable && !pwrite;
   assign idx    = paddr[7:2];

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_bus_off_backup: assert property (serial_bus_en != on_backup)
      else $error("bus enable does not follow supply state");
   a_backup_refused: assert property (psel && penable && on_backup |-> pslverr)
      else $error("access on backup not refused");
   a_refused_zero: assert property (rd_acc && on_backup && $past(on_backup)
      |-> prdata == 32'h0) else $error("read on backup returned data");
   a_mfp_quiet: assert property (on_backup && $past(on_backup)
      |-> !multi_function_pin_oe) else $error("pin driven while on backup");
   a_switch_cause: assert property ($rose(on_backup)
      |-> $past(below_switchover_threshold)) else $error("switch to backup without low supply");
   a_return_cause: assert property ($fell(on_backup)
      |-> !$past(below_switchover_threshold)) else $error("return to primary while supply low");
   a_backup_held: assert property (on_backup && below_switchover_threshold
      |=> on_backup) else $error("left backup while supply low");
   a_min_top_zero: assert property (rd_acc && idx[5:3] == 3'h3 && idx[1:0] == 2'h0
      |-> prdata[31:7] == 25'h0) else $error("stamp minutes top bits set");
   a_hour_top_zero: assert property (rd_acc && idx[5:3] == 3'h3 && idx[1:0] == 2'h1
      |-> prdata[31:7] == 25'h0) else $error("stamp hours top bits set");
   a_date_top_zero: assert property (rd_acc && idx[5:3] == 3'h3 && idx[1:0] == 2'h2
      |-> prdata[31:6] == 26'h0) else $error("stamp date top bits set");
endmodule

bind rtcts_top rtcts_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .pready(pready), .prdata(prdata), .pslverr(pslverr), .osc_tick(osc_tick),
   .below_switchover_threshold(below_switchover_threshold), .cur_time(cur_time),
   .trim_tick(trim_tick), .on_backup(on_backup), .serial_bus_en(serial_bus_en),
   .multi_function_pin_o(multi_function_pin_o), .multi_function_pin_oe(multi_function_pin_oe));

// File: bench/rtcts_host.sv
// Purpose: host processor model, bus master and calibration helpers
// Assumes: tasks are entered right after a rising clock edge
// Notes:   released address and data lines show the inverse of the last value
`include "rtcts_regs.svh"

module rtcts_host (
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb
);
   // ****************************************************************
   // bus cycles
   // ****************************************************************
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'h0;
   end

   task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      pstrb <= 4'hf;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~paddr;
      pwdata <= ~pwdata;
      @(posedge pclk);
   endtask

   // oscillator on, backup input on, trim cleared, then output chosen
   task automatic calib_prep(input logic [7:0] ctl);
      logic [7:0] d;
      logic       e;
      xfer(1'b1, `RTS_IDX_STATUS, 8'h88, d, e);
      xfer(1'b1, `RTS_IDX_TRIM, 8'h00, d, e);
      xfer(1'b1, `RTS_IDX_CONTROL, ctl, d, e);
   endtask

   // negative steps mean a fast oscillator, so the sign is cleared
   function automatic logic [7:0] trim_of(input int steps);
      return {steps < 0 ? 1'b0 : 1'b1, 7'(steps < 0 ? -steps : steps)};
   endfunction

   // trim steps from ideal and measured output frequency, both in mHz
   function automatic int steps_from_freq(input int f_ideal, input int f_meas);
      return (f_ideal - f_meas) * `RTS_OSC_HZ * `RTS_SECS_PER_MIN / (f_ideal * 2);
   endfunction

   // trim steps from seconds lost (positive) or gained (negative)
   function automatic int steps_from_ppm(input int sec_dev, input int sec_exp);
      int ppm;
      ppm = sec_dev * 1000000 / sec_exp;
      return ppm * `RTS_OSC_HZ * `RTS_SECS_PER_MIN / (1000000 * 2);
   endfunction
endmodule

// File: bench/testbench.sv
// Purpose: self-checking bench for trim, switchover and power-fail stamps
// Assumes: host model drives the register bus, oscillator ticks made here
// Notes:   SEC_TICKS shortened so one trimmed minute fits the run
`include "rtcts_regs.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import rtcts_pkg::*;
   localparam int SECS  = 512;
   localparam int LIMIT = 100000;
   logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]   paddr;
   logic [31:0]  pwdata, prdata;
   logic [3:0]   pstrb;
   logic         osc_tick, below, trim_tick, on_backup, serial_bus_en, mfp_oe, oe_prev;
   rtcts_stamp_t cur_time;
   int           n_errors, cmp_count, cycles, tt_cnt, oe_cnt;

   rtcts_top #(.SEC_TICKS(SECS)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .osc_tick(osc_tick),
      .below_switchover_threshold(below), .cur_time(cur_time), .trim_tick(trim_tick),
      .on_backup(on_backup), .serial_bus_en(serial_bus_en), .multi_function_pin_o(),
      .multi_function_pin_oe(mfp_oe));
   rtcts_host host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb));

   // ****************************************************************
   // clock, counters, helpers
   // ****************************************************************
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (trim_tick === 1'b1) tt_cnt <= tt_cnt + 1;
      oe_prev <= mfp_oe;
      if (mfp_oe !== oe_prev) oe_cnt <= oe_cnt + 1;
      if (cycles == LIMIT) begin
         n_errors++;
         wrap_up();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      logic [7:0] r;
      logic       e;
      host.xfer(1'b1, idx, d, r, e);
   endtask

   task automatic rd(input logic [5:0] idx, output logic [7:0] d, output logic e);
      host.xfer(1'b0, idx, 8'h00, d, e);
   endtask

   task automatic supply(input logic low);
      below <= low;
      repeat (3) @(posedge pclk);
   endtask

   // count trimmed ticks and pin edges over a window after a settling run
   task automatic run_ticks(input int warm, input int win, input int gap, input int et,
                            input int eo);
      int t0, o0;
      for (int i = 0; i < warm + win; i++) begin
         osc_tick <= 1'b1;
         @(posedge pclk);
         if (i == warm) t0 = tt_cnt;
         if (i == warm) o0 = oe_cnt;
         osc_tick <= 1'b0;
         repeat (gap - 1) @(posedge pclk);
      end
      repeat (4) @(posedge pclk);
      chk("trimmed ticks", tt_cnt - t0, et);
      chk("pin edges", oe_cnt - o0, eo);
   endtask

   task automatic stamps(input logic [31:0] edn, input logic [31:0] eup);
      logic [7:0] d;
      logic       e;
      for (int i = 0; i < 8; i++) begin
         rd(6'h18 + 6'(i), d, e);
         chk("stamp", d, i < 4 ? edn[8*i+:8] : eup[8*(i-4)+:8]);
      end
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_regs;
      logic [7:0] d;
      logic       e;
      logic [5:0] idx [4] = '{`RTS_IDX_DN_HOUR, `RTS_IDX_DN_DATE, `RTS_IDX_DN_MTH,
                              `RTS_IDX_UP_MIN};
      logic [7:0] msk [4] = '{8'h7f, 8'h3f, 8'hff, 8'h7f};
      stamps(32'h0, 32'h0);
      rd(6'h10, d, e);
      chk("unmapped", {e, d}, 9'h100);
      for (int i = 0; i < 4; i++) begin
         wr(idx[i], 8'hff);
         rd(idx[i], d, e);
         chk("stamp mask", d, msk[i]);
      end
   endtask

   task automatic t_trim;
      host.calib_prep(8'h44);
      run_ticks(16, 1024, 4, 1024, 4);
      wr(`RTS_IDX_CONTROL, 8'h04);
      wr(`RTS_IDX_TRIM, host.trim_of(1));
      run_ticks(16, 1024, 4, 1032, 0);
      wr(`RTS_IDX_TRIM, host.trim_of(host.steps_from_freq(32768000, 32768100)));
      run_ticks(16, 1024, 4, 1000, 0);
      wr(`RTS_IDX_CONTROL, 8'h00);
      wr(`RTS_IDX_TRIM, host.trim_of(host.steps_from_ppm(-2, 1000000)));
      run_ticks(16, 60 * SECS, 2, 60 * SECS - 2, 0);
   endtask

   task automatic t_backup;
      logic [7:0] d;
      logic       e;
      wr(`RTS_IDX_CONTROL, 8'h44);
      wr(`RTS_IDX_TRIM, 8'h81);
      wr(`RTS_IDX_STATUS, 8'h80);
      supply(1'b1);
      chk("no switch", on_backup, 1'b0);
      supply(1'b0);
      wr(`RTS_IDX_STATUS, 8'h88);
      supply(1'b1);
      chk("switched", {on_backup, serial_bus_en}, 2'b10);
      rd(`RTS_IDX_TRIM, d, e);
      chk("refused", {e, d}, 9'h100);
      run_ticks(16, 1024, 4, 1032, 0);
      supply(1'b0);
      rd(`RTS_IDX_TRIM, d, e);
      chk("kept", {on_backup, e, d}, 10'h081);
   endtask

   task automatic t_stamp;
      logic [7:0] d;
      logic       e;
      wr(`RTS_IDX_STATUS, 8'h88);
      stamps(32'h0, 32'h0);
      cur_time <= 32'hd2f1f2d9;
      supply(1'b1);
      cur_time <= 32'h21051307;
      supply(1'b0);
      stamps(32'hd23172d9 & 32'hff3f7f7f, 32'h21051307);
      rd(`RTS_IDX_STATUS, d, e);
      chk("loss flag", d[4], 1'b1);
      cur_time <= 32'h0;
      supply(1'b1);
      supply(1'b0);
      stamps(32'hd2317259, 32'h21051307);
      wr(`RTS_IDX_STATUS, 8'h88);
      stamps(32'h0, 32'h0);
   endtask

   // output rates, and oscillator gating by start and external input
   task automatic t_clkout;
      wr(`RTS_IDX_STATUS, 8'h08);
      wr(`RTS_IDX_CONTROL, 8'h41);
      run_ticks(16, 64, 4, 0, 0);
      wr(`RTS_IDX_CONTROL, 8'h49);
      run_ticks(16, 64, 4, 64, 16);
      wr(`RTS_IDX_STATUS, 8'h88);
      wr(`RTS_IDX_CONTROL, 8'h42);
      run_ticks(16, 64, 4, 64, 32);
      wr(`RTS_IDX_CONTROL, 8'h43);
      run_ticks(16, 64, 4, 64, 64);
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      presetn = 1'b0;
      osc_tick = 1'b0;
      below = 1'b0;
      cur_time = 32'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_trim();
      t_backup();
      t_stamp();
      t_clkout();
      wrap_up();
   end
endmodule
